/* File: include/tms_defines.svh */
`ifndef TMS_DEFINES_SVH
`define TMS_DEFINES_SVH
`define TMS_ADDR_CTRL 16'h28A0
`define TMS_ADDR_START 16'h28B4
`define TMS_ADDR_RES_HI 16'h2881
`define TMS_ADDR_RES_LO 16'h2882
`define TMS_PER_LSB 0
`define TMS_PER_MSB 2
`define TMS_BUSY_BIT 3
`define TMS_BAT_BIT 4
`define TMS_PWR_BIT 6
`define TMS_BSEL_BIT 7
`define TMS_START_BIT 6
`define TMS_RES_LO_LSB 5
`define TMS_PER_BASE 3
`define TMS_PER_CONT 3'h7
`define TMS_PER_OFF 3'h0
`define TMS_CLK_HZ 25000000
`define TMS_BUSY_MS 6
`define TMS_BUSY_CYC ((`TMS_CLK_HZ / 1000) * `TMS_BUSY_MS)
`define TMS_CTRL_RST 8'h00
`endif

/* File: include/tms_pkg.sv */
package tms_pkg;
	typedef enum logic [1:0] {
		TMS_NORMAL,
		TMS_BROWNOUT,
		TMS_DISPLAY,
		TMS_SLEEP
	} tms_mode_t;
	typedef enum {
		TMS_IDLE,
		TMS_TEMP,
		TMS_BAT
	} tms_state_t;
endpackage

/* File: rtl/tms_tick.sv */
`timescale 1ns/1ps
`default_nettype none
// One-second tick divider feeding the period scheduler
module tms_tick #(
	parameter int unsigned DIV = 25000000
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);
	logic [31:0] cnt_reg;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			cnt_reg <= 32'h0;
		else if (cnt_reg >= DIV - 1)
			cnt_reg <= 32'h0;
		else
			cnt_reg <= cnt_reg + 32'h1;
	assign tick = (cnt_reg >= DIV - 1);
endmodule // tms_tick
`default_nettype wire

/* File: rtl/tms_busy.sv */
`timescale 1ns/1ps
`default_nettype none
// Write-lockout timer for the control byte
module tms_busy #(
	parameter int unsigned CYCLES = 150000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	output logic busy
);
	logic [31:0] cnt_reg;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			cnt_reg <= 32'h0;
		else if (start && cnt_reg == 32'h0)
			cnt_reg <= CYCLES;
		else if (cnt_reg != 32'h0)
			cnt_reg <= cnt_reg - 32'h1;
	assign busy = (cnt_reg != 32'h0);
endmodule // tms_busy
`default_nettype wire

/* File: rtl/tms_sched.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tms_defines.svh"
module tms_sched
	import tms_pkg::*;
#(
	parameter int unsigned TICK_DIV = `TMS_CLK_HZ,
	parameter int unsigned BUSY_CYC = `TMS_BUSY_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [1:0] power_mode,
	output logic meas_start,
	output logic meas_battery,
	input wire logic meas_done,
	input wire logic [10:0] meas_result,
	output logic monitored_battery_select,
	output logic sensor_supply_digital
);
	logic [2:0] temp_period_code_reg;
	logic battery_with_temp_enable_reg;
	logic sensor_power_select_reg;
	logic monitored_battery_select_reg;
	logic oneshot_measure_trigger_reg;
	logic [10:0] sensor_result_word_reg;
	logic [7:0] rdata_reg;
	logic [8:0] sec_cnt_reg;
	logic [1:0] mode_s1_reg;
	logic [1:0] mode_s2_reg;
	logic done_s1_reg;
	logic done_s2_reg;
	logic done_d_reg;
	tms_state_t state_reg;
	logic sec_tick;
	logic control_byte_write_pending;
	logic low_power;
	logic ctrl_wr;
	logic period_hit;
	logic done_rise;
	logic auto_req;
	logic one_req;

	// Expected interval in seconds minus one for codes 1-6
	// Longest interval is 512 s, so the counter needs nine bits
	function automatic logic [8:0] period_last(input logic [2:0] code);
		logic [9:0] p;
		p = 10'h1 << (`TMS_PER_BASE + code);
		return 9'(p - 10'h1);
	endfunction

	tms_tick #(.DIV(TICK_DIV)) u_tick (
		.clk(clk),
		.rst(rst),
		.tick(sec_tick)
	);

	tms_busy #(.CYCLES(BUSY_CYC)) u_busy (
		.clk(clk),
		.rst(rst),
		.start(ctrl_wr),
		.busy(control_byte_write_pending)
	);

	// Mode and done come from other domains
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			mode_s1_reg <= 2'h0;
			mode_s2_reg <= 2'h0;
			done_s1_reg <= 1'b0;
			done_s2_reg <= 1'b0;
			done_d_reg <= 1'b0;
		end
		else
		begin
			mode_s1_reg <= power_mode;
			mode_s2_reg <= mode_s1_reg;
			done_s1_reg <= meas_done;
			done_s2_reg <= done_s1_reg;
			done_d_reg <= done_s2_reg;
		end

	assign done_rise = done_s2_reg && !done_d_reg;
	assign low_power = (mode_s2_reg == 2'(TMS_SLEEP)) ||
		(mode_s2_reg == 2'(TMS_DISPLAY));
	assign ctrl_wr = wr && addr == `TMS_ADDR_CTRL &&
		!control_byte_write_pending;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			temp_period_code_reg <= 3'h0;
			battery_with_temp_enable_reg <= 1'b0;
			sensor_power_select_reg <= 1'b0;
			monitored_battery_select_reg <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			temp_period_code_reg <= wdata[`TMS_PER_MSB:`TMS_PER_LSB];
			battery_with_temp_enable_reg <= wdata[`TMS_BAT_BIT];
			sensor_power_select_reg <= wdata[`TMS_PWR_BIT];
			monitored_battery_select_reg <= wdata[`TMS_BSEL_BIT];
		end

	// Interval counter restarts on any period change
	always_ff @(posedge clk or posedge rst)
		if (rst)
			sec_cnt_reg <= 9'h0;
		else if (ctrl_wr || temp_period_code_reg == `TMS_PER_OFF ||
			temp_period_code_reg == `TMS_PER_CONT)
			sec_cnt_reg <= 9'h0;
		else if (sec_tick)
			sec_cnt_reg <= period_hit ? 9'h0 : sec_cnt_reg + 9'h1;

	assign period_hit = sec_tick &&
		sec_cnt_reg == period_last(temp_period_code_reg);
	// No power-mode term: automatic runs in all modes
	assign auto_req = temp_period_code_reg != `TMS_PER_OFF &&
		(temp_period_code_reg == `TMS_PER_CONT || period_hit);
	assign one_req = oneshot_measure_trigger_reg && !low_power &&
		temp_period_code_reg == `TMS_PER_OFF;

	always_ff @(posedge clk or posedge rst)
		if (rst)
			state_reg <= TMS_IDLE;
		else
			case (state_reg)
				TMS_IDLE:
					if (auto_req || one_req)
						state_reg <= TMS_TEMP;
				TMS_TEMP:
					if (done_rise)
						state_reg <= battery_with_temp_enable_reg ?
							TMS_BAT : TMS_IDLE;
				TMS_BAT:
					if (done_rise)
						state_reg <= TMS_IDLE;
				default:
					state_reg <= TMS_IDLE;
			endcase

	// Set from software wins over the hardware clear
	always_ff @(posedge clk or posedge rst)
		if (rst)
			oneshot_measure_trigger_reg <= 1'b0;
		else if (wr && addr == `TMS_ADDR_START && wdata[`TMS_START_BIT])
			oneshot_measure_trigger_reg <= 1'b1;
		else if (state_reg == TMS_TEMP && done_rise)
			oneshot_measure_trigger_reg <= 1'b0;
		else if (wr && addr == `TMS_ADDR_START)
			oneshot_measure_trigger_reg <= 1'b0;

	always_ff @(posedge clk or posedge rst)
		if (rst)
			sensor_result_word_reg <= 11'h0;
		else if (state_reg == TMS_TEMP && done_rise)
			sensor_result_word_reg <= meas_result;

	assign meas_start = state_reg != TMS_IDLE;
	assign meas_battery = state_reg == TMS_BAT;
	assign monitored_battery_select = monitored_battery_select_reg;
	assign sensor_supply_digital = sensor_power_select_reg &&
		!low_power;

	always_ff @(posedge clk or posedge rst)
		if (rst)
			rdata_reg <= 8'h00;
		else if (rd)
			case (addr)
				`TMS_ADDR_CTRL:
					rdata_reg <= {monitored_battery_select_reg,
						sensor_power_select_reg, 1'b0,
						battery_with_temp_enable_reg,
						control_byte_write_pending, temp_period_code_reg};
				`TMS_ADDR_START:
					rdata_reg <= {1'b0, oneshot_measure_trigger_reg, 6'h00};
				`TMS_ADDR_RES_HI:
					rdata_reg <= sensor_result_word_reg[10:3];
				`TMS_ADDR_RES_LO:
					rdata_reg <= {sensor_result_word_reg[2:0], 5'h00};
				default:
					rdata_reg <= 8'h00;
			endcase
		else
			rdata_reg <= 8'h00;
	assign rdata = rdata_reg;
endmodule // tms_sched
`default_nettype wire

/* File: testbench/tms_sched_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tms_sched_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [1:0] power_mode,
	input wire logic meas_start,
	input wire logic meas_battery,
	input wire logic meas_done,
	input wire logic [10:0] meas_result,
	input wire logic monitored_battery_select,
	input wire logic sensor_supply_digital
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr_ctl; wr && addr == 16'h28A0; endsequence
	sequence s_rd_ctl; rd && addr == 16'h28A0; endsequence
	property p_idle; !rd |=> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_unmap; rd && addr[15:8] != 8'h28 |=> rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	// Idle busy read first, so the write is known to be accepted
	property p_busy;
		s_rd_ctl ##1 !rdata[3] ##1 s_wr_ctl ##2 s_rd_ctl |=> rdata[3];
	endproperty
	a_busy: assert property (p_busy) else $error("busy not set");
	property p_bsel;
		$changed(monitored_battery_select) |-> $past(wr && addr == 16'h28A0);
	endproperty
	a_bsel: assert property (p_bsel) else $error("select moved");
	property p_sup; power_mode[1] [*4] |-> !sensor_supply_digital; endproperty
	a_sup: assert property (p_sup) else $error("supply not forced");
	property p_bat; meas_battery |-> meas_start; endproperty
	a_bat: assert property (p_bat) else $error("battery alone");
	property p_first; $rose(meas_start) |-> !meas_battery; endproperty
	a_first: assert property (p_first) else $error("battery first");
	property p_hold; !meas_done [*4] ##0 meas_start |=> meas_start; endproperty
	a_hold: assert property (p_hold) else $error("start dropped");
endmodule // tms_sched_monitor
bind tms_sched tms_sched_monitor u_mon (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .power_mode(power_mode),
	.meas_start(meas_start), .meas_battery(meas_battery),
	.meas_done(meas_done), .meas_result(meas_result),
	.monitored_battery_select(monitored_battery_select),
	.sensor_supply_digital(sensor_supply_digital));
`default_nettype wire

/* File: testbench/test_tms_sched.sv */
`timescale 1ns/1ps
`default_nettype none
module test_tms_sched;
	logic clk = 0, rst = 1, wr = 0, rd = 0, done = 0;
	logic [15:0] addr = 0;
	logic [7:0] wdata = 0, rdata, v;
	logic [1:0] pm = 0;
	logic [10:0] res = 0;
	logic ms, mb, bsel, sup;
	int miscompares = 0, checks_done = 0, cyc = 0, c0, per;
	localparam int TICK = 10;
	always #20 clk = ~clk;
	always @(posedge clk)
		if (++cyc > 20000)
		begin
			miscompares++;
			stop_test();
		end
	tms_sched #(.TICK_DIV(TICK), .BUSY_CYC(20)) dut (.clk(clk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.power_mode(pm), .meas_start(ms), .meas_battery(mb),
		.meas_done(done), .meas_result(res),
		.monitored_battery_select(bsel), .sensor_supply_digital(sup));
	task stop_test;
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task cmp(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr_t(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd_t(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a; rd <= 1;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		cmp({8'h00, rdata}, {8'h00, e});
	endtask
	// Cycles between automatic starts: 2^(3+code) ticks
	function automatic int span(input int code);
		return (1 << (3 + code)) * TICK;
	endfunction
	task wt(input int lim);
		for (int n = 0; !ms && n < lim; n++)
			@(negedge clk);
	endtask
	// Done held long enough to cross the input synchroniser
	task srv;
		repeat (2) @(posedge clk);
		done <= 1;
		repeat (5) @(posedge clk);
		done <= 0;
		repeat (5) @(posedge clk);
	endtask
	initial
	begin
		v = 8'($urandom(32'h3EDC));
		repeat (4) @(posedge clk);
		rst <= 0;
		rd_t(16'h28A0, 8'h00);
		rd_t(16'h28B4, 8'h00);
		rd_t({8'h30, v}, 8'h00);
		@(posedge clk);
		res <= 11'($urandom);
		wr_t(16'h28B4, 8'h40);
		wt(10);
		cmp(ms, 1);
		cmp(mb, 0);
		srv;
		rd_t(16'h28B4, 8'h00);
		rd_t(16'h2881, res[10:3]);
		rd_t(16'h2882, {res[2:0], 5'h00});
		repeat (50) @(posedge clk);
		cmp(ms, 0);
		v = {v[7], 7'h40};
		rd_t(16'h28A0, 8'h00);
		wr_t(16'h28A0, v);
		rd_t(16'h28A0, v | 8'h08);
		wr_t(16'h28A0, 8'h00);
		repeat (25) @(posedge clk);
		rd_t(16'h28A0, v);
		cmp(bsel, v[7]);
		cmp(sup, 1);
		@(posedge clk);
		pm <= {1'b1, 1'($urandom)};
		wr_t(16'h28B4, 8'h40);
		wt(50);
		cmp(ms, 0);
		cmp(sup, 0);
		wr_t(16'h28B4, 8'h00);
		wr_t(16'h28A0, 8'h11);
		wt(200);
		c0 = cyc;
		srv;
		cmp(mb, 1);
		srv;
		wt(200);
		cmp(16'(cyc - c0), 16'(span(1)));
		srv;
		srv;
		pm <= 0;
		repeat (25) @(posedge clk);
		wr_t(16'h28A0, 8'h07);
		wt(20);
		srv;
		cmp(ms, 1);
		repeat (25) @(posedge clk);
		wr_t(16'h28A0, 8'h00);
		srv;
		repeat (200) @(posedge clk);
		cmp(ms, 0);
		// Codes 2-6; only code 6 reaches the top of the interval counter
		per = 2 + $urandom % 5;
		wr_t(16'h28A0, 8'(per));
		wt(6000);
		c0 = cyc;
		srv;
		wt(6000);
		cmp(16'(cyc - c0), 16'(span(per)));
		stop_test();
	end
endmodule // test_tms_sched
`default_nettype wire
